// [src/iusm_pkg.sv]
package iusm_pkg;

    // ==========================================================
    // Register map (byte addresses on APB)
    localparam logic [11:0] OFS_SYSCTL = 12'h000;
    localparam logic [11:0] OFS_READBACK = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_CONTROL = 12'h00C;
    localparam logic [11:0] OFS_JUMPER = 12'h010;

    // ==========================================================
    // System control command codes
    localparam logic [7:0] CMD_MASK = 8'h87;
    localparam logic [7:0] CODE_NOP = 8'h00;
    localparam logic [7:0] CODE_STARTUP_CLR = 8'h06;
    localparam logic [7:0] CODE_STARTUP_SET = 8'h07;
    localparam logic [7:0] CODE_FAULT_SET = 8'h82;
    localparam logic [7:0] CODE_FAULT_CLR = 8'h83;
    localparam logic [7:0] CODE_INHIBIT_CLR = 8'h84;
    localparam logic [7:0] CODE_FILTER_ON = 8'h85;
    localparam logic [7:0] CODE_FILTER_OFF = 8'h86;

    typedef enum {
        CMD_NONE,
        CMD_STARTUP_CLR,
        CMD_STARTUP_SET,
        CMD_FAULT_SET,
        CMD_FAULT_CLR,
        CMD_INHIBIT_CLR,
        CMD_FILTER_ON,
        CMD_FILTER_OFF
    } iusm_cmd_t;

    // ==========================================================
    // Status and control field positions
    localparam int ST_STARTUP = 0;
    localparam int ST_SW_FAULT = 1;
    localparam int ST_FILTER = 2;
    localparam int ST_PERM_INH = 3;
    localparam int ST_CLK_INH = 4;
    localparam int ST_CLK_LOST = 5;
    localparam int ST_SYNC_FAULT = 6;
    localparam int ST_BUS_CTRL = 7;
    localparam int ST_CLR_PEND = 8;
    localparam int CTL_BUS = 0;
    localparam int JMP_FILTER = 0;
    localparam int JMP_BUS_CTRL = 1;

    // ==========================================================
    // Reset values
    localparam logic STARTUP_RST = 1'b1;
    localparam logic [7:0] READBACK_RST = 8'h00;

    // ==========================================================
    // Timing
    localparam longint CLK_KHZ = 250000;
    localparam longint ACC_WD_MS = 3000;
    localparam longint STRETCH_MS = 200;
    localparam longint CLR_DELAY_US = 50;
    localparam longint EXT_CLK_WD_US = 1000;
    localparam longint PERM_ALARM_MS = 100;
    localparam longint FILTER_NS = 1000;
    localparam longint ACC_WD_CYC = ACC_WD_MS * CLK_KHZ;
    localparam longint STRETCH_CYC = STRETCH_MS * CLK_KHZ;
    localparam longint CLR_DELAY_CYC = (CLR_DELAY_US * CLK_KHZ + 999) / 1000;
    localparam longint EXT_CLK_WD_CYC = EXT_CLK_WD_US * CLK_KHZ / 1000;
    localparam longint PERM_ALARM_CYC = PERM_ALARM_MS * CLK_KHZ;
    localparam longint FILTER_CYC = (FILTER_NS * CLK_KHZ + 999999) / 1000000;

endpackage

// [src/iusm_timer.sv]
`timescale 1ns/1ps
module iusm_timer
    import iusm_pkg::*;
#(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic run,
    input wire logic [W-1:0] load,
    // Status
    output logic busy,
    output logic done
);

    logic [W-1:0] cnt;

    // ==========================================================
    // Down counter
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= '0;
            done <= 1'b0;
        end else if (start) begin
            cnt <= load;
            done <= 1'b0;
        end else if (run && cnt != '0) begin
            cnt <= cnt - 1'b1;
            done <= (cnt == {{(W-1){1'b0}}, 1'b1});
        end else begin
            done <= 1'b0;
        end
    end

    assign busy = (cnt != '0);

endmodule

// [src/iusm_top.sv]
// Functional notes
// [R1] Decode ignores bits 6..3.
// [R2] Read-back holds last control byte.
// [R3] Zero does nothing.
// [R4] Code 6 clears start-up flag, 7 sets it.
// [R5] Start-up flag set after reset.
// [R6] Watchdog idle while start-up flag set.
// [R7] Code 130 sets software fault.
// [R8] Code 131 clears fault flops only.
// [R9] Software fault clear delayed 50 to 100 us.
// [R10] Code 132 clears all inhibitions.
// [R11] Pending permanent alarm passes once, then re-inhibited.
// [R12] Code 133 filter on, 134 off.
// [R13] Filter enable after start-up from jumper.
// [R14] Watchdog resets controller after about 3 s.
// [R15] Non-jumper or owned module access restarts watchdog.
// [R16] Host accesses cyclically.
// [R17] Watchdog reset lasts at least 200 ms.
// [R18] Sync fault only in synchronous mode.
// [R19] Lost external clock inhibits; lost internal resets.
// [R20] Fault indicator on supply, fuse, channel or common fault.
// [R21] Good field and alarm supplies: faults drive both outputs.
// [R22] Control-active shows bus ownership; jumper reset, software set.
// [R23] Without bus control the bus is disabled.
// [R24] Unknown codes only update read-back.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module iusm_top
    import iusm_pkg::*;
#(
    parameter longint ACC_WD_CYCLES = ACC_WD_CYC,
    parameter longint STRETCH_CYCLES = STRETCH_CYC,
    parameter longint CLR_DELAY_CYCLES = CLR_DELAY_CYC,
    parameter longint PERM_ALARM_CYCLES = PERM_ALARM_CYC
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Straps
    input wire logic JUMPER_FILTER,
    input wire logic JUMPER_BUS_CTRL,
    // Monitored conditions
    input wire logic BUS_SUPPLY_OK,
    input wire logic FIELD_SUPPLY_OK,
    input wire logic ALARM_SUPPLY_OK,
    input wire logic MODULE_FUSE_PRESENT,
    input wire logic SINGLE_CHANNEL_FAULT,
    input wire logic SYNC_MODE,
    input wire logic SYNC_COMPARE_ERROR,
    input wire logic EXTERNAL_CYCLE_CLOCK,
    input wire logic INTERNAL_CLOCK_OK,
    input wire logic CABINET_BLINK_CLOCK,
    // Extension bus side
    input wire logic IO_MODULE_ACCESS,
    input wire logic PROCESS_ALARM_INTERRUPT_IN,
    output logic PROCESS_ALARM_INTERRUPT_OUT,
    output logic EXTENSION_IO_BUS_ENABLE,
    // Indications
    output logic FAULT_INDICATOR,
    output logic STATIC_FAULT_OUTPUT,
    output logic DYNAMIC_FAULT_OUTPUT,
    output logic REDUNDANT_FAULT_SIGNAL,
    output logic CONTROL_ACTIVE_INDICATOR,
    output logic CONTROLLER_RESET
);

    // ==========================================================
    // Helpers
    function automatic iusm_cmd_t decode_cmd(input logic [7:0] data);
        logic [7:0] code;
        code = data & CMD_MASK;
        case (code)
            CODE_STARTUP_CLR: decode_cmd = CMD_STARTUP_CLR;
            CODE_STARTUP_SET: decode_cmd = CMD_STARTUP_SET;
            CODE_FAULT_SET: decode_cmd = CMD_FAULT_SET;
            CODE_FAULT_CLR: decode_cmd = CMD_FAULT_CLR;
            CODE_INHIBIT_CLR: decode_cmd = CMD_INHIBIT_CLR;
            CODE_FILTER_ON: decode_cmd = CMD_FILTER_ON;
            CODE_FILTER_OFF: decode_cmd = CMD_FILTER_OFF;
            default: decode_cmd = CMD_NONE;
        endcase
    endfunction

    function automatic logic is_mapped(input logic [11:0] addr);
        is_mapped = (addr == OFS_SYSCTL) || (addr == OFS_READBACK) ||
                    (addr == OFS_STATUS) || (addr == OFS_CONTROL) ||
                    (addr == OFS_JUMPER);
    endfunction

    // ==========================================================
    // Declarations
    iusm_cmd_t cmd;
    logic [31:0] rd_mux;
    logic [7:0] readback;
    logic core_rst, apb_done, apb_wr, wr_sys, wr_ctl, acc_restart, startup_flag, sw_fault;
    logic clr_pending, filter_en, perm_inh, clk_inh, clk_lost, sync_fault, bus_ctrl, pass_once;
    logic alarm_q, alarm_filt, alarm_eff, ext_clk_q, ext_armed, fault_any, acc_wd_done;

    assign core_rst = RST | CONTROLLER_RESET;

    // ==========================================================
    // APB slave, one wait state
    assign apb_done = PSEL & PENABLE & PREADY;
    assign apb_wr = apb_done & PWRITE & ~PSLVERR;
    assign wr_sys = apb_wr & (PADDR == OFS_SYSCTL);
    assign wr_ctl = apb_wr & (PADDR == OFS_CONTROL);
    assign cmd = wr_sys ? decode_cmd(PWDATA[7:0]) : CMD_NONE; // [R1] [R3] [R24]

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (PADDR)
            OFS_READBACK: rd_mux[7:0] = readback; // [R2]
            OFS_STATUS: begin
                rd_mux[ST_STARTUP] = startup_flag;
                rd_mux[ST_SW_FAULT] = sw_fault;
                rd_mux[ST_FILTER] = filter_en;
                rd_mux[ST_PERM_INH] = perm_inh;
                rd_mux[ST_CLK_INH] = clk_inh;
                rd_mux[ST_CLK_LOST] = clk_lost;
                rd_mux[ST_SYNC_FAULT] = sync_fault;
                rd_mux[ST_BUS_CTRL] = bus_ctrl;
                rd_mux[ST_CLR_PEND] = clr_pending;
            end
            OFS_CONTROL: rd_mux[CTL_BUS] = bus_ctrl;
            OFS_JUMPER: begin
                rd_mux[JMP_FILTER] = JUMPER_FILTER;
                rd_mux[JMP_BUS_CTRL] = JUMPER_BUS_CTRL;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= PSEL & PENABLE & ~PREADY;
            if (PSEL && PENABLE && !PREADY) begin
                PSLVERR <= ~is_mapped(PADDR);
                PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
            end else begin
                PSLVERR <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Read-back latch
    always_ff @(posedge CLOCK) begin
        if (core_rst) begin
            readback <= READBACK_RST;
        end else if (wr_sys || wr_ctl) begin
            readback <= PWDATA[7:0]; // [R2] [R1] [R24]
        end
    end

    // ==========================================================
    // Start-up flag
    always_ff @(posedge CLOCK) begin
        if (core_rst) begin
            startup_flag <= STARTUP_RST; // [R5]
        end else if (cmd == CMD_STARTUP_CLR) begin
            startup_flag <= 1'b0; // [R4]
        end else if (cmd == CMD_STARTUP_SET) begin
            startup_flag <= 1'b1; // [R4]
        end
    end

    // ==========================================================
    // Access watchdog and stretched controller reset
    assign acc_restart = (apb_done & ~PSLVERR & (PADDR != OFS_JUMPER)) |
                         (IO_MODULE_ACCESS & bus_ctrl); // [R15] [R23]
    logic stretch_busy, clr_done, ext_wd_done, perm_done, filt_done;

    iusm_timer #(.W(32)) u_acc_wd (.clk(CLOCK), .rst(core_rst),
        .start(acc_restart | startup_flag), .run(~startup_flag), // [R6] [R15]
        .load(ACC_WD_CYCLES[31:0]), .busy(), .done(acc_wd_done)); // [R14]

    iusm_timer #(.W(32)) u_stretch (.clk(CLOCK), .rst(RST),
        .start(acc_wd_done | ~INTERNAL_CLOCK_OK), .run(1'b1), // [R14] [R19]
        .load(STRETCH_CYCLES[31:0]), .busy(stretch_busy), .done()); // [R17]

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            CONTROLLER_RESET <= 1'b0;
        end else begin
            CONTROLLER_RESET <= stretch_busy | acc_wd_done | ~INTERNAL_CLOCK_OK; // [R17]
        end
    end

    // ==========================================================
    // Software common fault with delayed clear
    iusm_timer #(.W(32)) u_clr_dly (.clk(CLOCK), .rst(core_rst | (cmd == CMD_FAULT_SET)),
        .start(cmd == CMD_FAULT_CLR), .run(1'b1), // [R8]
        .load(CLR_DELAY_CYCLES[31:0]), .busy(clr_pending), .done(clr_done)); // [R9]

    always_ff @(posedge CLOCK) begin
        if (core_rst) begin
            sw_fault <= 1'b0;
        end else if (cmd == CMD_FAULT_SET) begin
            sw_fault <= 1'b1; // [R7]
        end else if (clr_done) begin
            sw_fault <= 1'b0; // [R8] [R9]
        end
    end

    // ==========================================================
    // Monitoring fault flops
    always_ff @(posedge CLOCK) begin
        if (core_rst) begin
            sync_fault <= 1'b0;
        end else if (SYNC_MODE && SYNC_COMPARE_ERROR) begin
            sync_fault <= 1'b1; // [R18]
        end else if (cmd == CMD_FAULT_CLR) begin
            sync_fault <= 1'b0; // [R8]
        end
    end

    always_ff @(posedge CLOCK) begin
        if (core_rst) begin
            ext_clk_q <= 1'b0;
            ext_armed <= 1'b0;
        end else begin
            ext_clk_q <= EXTERNAL_CYCLE_CLOCK;
            ext_armed <= 1'b1;
        end
    end

    iusm_timer #(.W(32)) u_ext_wd (.clk(CLOCK), .rst(core_rst),
        .start((EXTERNAL_CYCLE_CLOCK & ~ext_clk_q) | ~ext_armed), .run(1'b1),
        .load(EXT_CLK_WD_CYC[31:0]), .busy(), .done(ext_wd_done)); // [R19]

    always_ff @(posedge CLOCK) begin
        if (core_rst) begin
            clk_lost <= 1'b0;
        end else if (ext_wd_done) begin
            clk_lost <= 1'b1; // [R19]
        end else if (cmd == CMD_FAULT_CLR) begin
            clk_lost <= 1'b0; // [R8]
        end
    end

    // ==========================================================
    // Alarm filter
    always_ff @(posedge CLOCK) begin
        if (core_rst) begin
            filter_en <= 1'b0;
        end else if (!ext_armed) begin
            filter_en <= JUMPER_FILTER; // [R13]
        end else if (cmd == CMD_FILTER_ON) begin
            filter_en <= 1'b1; // [R12]
        end else if (cmd == CMD_FILTER_OFF) begin
            filter_en <= 1'b0; // [R12]
        end
    end

    iusm_timer #(.W(32)) u_filt (.clk(CLOCK), .rst(core_rst),
        .start(PROCESS_ALARM_INTERRUPT_IN != alarm_q), .run(1'b1),
        .load(FILTER_CYC[31:0]), .busy(), .done(filt_done)); // [R12]

    always_ff @(posedge CLOCK) begin
        if (core_rst) begin
            alarm_q <= 1'b0;
            alarm_filt <= 1'b0;
        end else begin
            alarm_q <= PROCESS_ALARM_INTERRUPT_IN;
            if (filt_done) begin
                alarm_filt <= alarm_q; // [R12]
            end
        end
    end

    assign alarm_eff = filter_en ? alarm_filt : alarm_q;

    // ==========================================================
    // Alarm inhibitions
    iusm_timer #(.W(32)) u_perm (.clk(CLOCK), .rst(core_rst),
        .start(~alarm_eff), .run(1'b1),
        .load(PERM_ALARM_CYCLES[31:0]), .busy(), .done(perm_done)); // [R11]

    always_ff @(posedge CLOCK) begin
        if (core_rst) begin
            perm_inh <= 1'b0;
            pass_once <= 1'b0;
        end else if (cmd == CMD_INHIBIT_CLR) begin
            perm_inh <= perm_done; // [R10]
            pass_once <= perm_inh & alarm_eff; // [R11]
        end else begin
            pass_once <= 1'b0;
            if (perm_done || (pass_once && alarm_eff)) begin
                perm_inh <= 1'b1; // [R11]
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (core_rst) begin
            clk_inh <= 1'b0;
        end else if (ext_wd_done) begin
            clk_inh <= 1'b1; // [R19]
        end else if (cmd == CMD_INHIBIT_CLR) begin
            clk_inh <= 1'b0; // [R10]
        end
    end

    always_ff @(posedge CLOCK) begin
        if (core_rst) begin
            PROCESS_ALARM_INTERRUPT_OUT <= 1'b0;
        end else begin
            PROCESS_ALARM_INTERRUPT_OUT <= alarm_eff & ~perm_inh & ~clk_inh & bus_ctrl;
        end
    end

    // ==========================================================
    // Bus control
    always_ff @(posedge CLOCK) begin
        if (core_rst) begin
            bus_ctrl <= 1'b0;
        end else if (!ext_armed) begin
            bus_ctrl <= JUMPER_BUS_CTRL; // [R22]
        end else if (wr_ctl) begin
            bus_ctrl <= PWDATA[CTL_BUS]; // [R22]
        end
    end

    always_ff @(posedge CLOCK) begin
        if (core_rst) begin
            CONTROL_ACTIVE_INDICATOR <= 1'b0;
            EXTENSION_IO_BUS_ENABLE <= 1'b0;
        end else begin
            CONTROL_ACTIVE_INDICATOR <= bus_ctrl; // [R22]
            EXTENSION_IO_BUS_ENABLE <= bus_ctrl; // [R23]
        end
    end

    // ==========================================================
    // Fault indications
    assign fault_any = ~BUS_SUPPLY_OK | ~FIELD_SUPPLY_OK | ~MODULE_FUSE_PRESENT |
                       SINGLE_CHANNEL_FAULT | sw_fault | sync_fault; // [R20]

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            FAULT_INDICATOR <= 1'b0;
            STATIC_FAULT_OUTPUT <= 1'b0;
            DYNAMIC_FAULT_OUTPUT <= 1'b0;
            REDUNDANT_FAULT_SIGNAL <= 1'b0;
        end else begin
            FAULT_INDICATOR <= fault_any & CABINET_BLINK_CLOCK; // [R20]
            STATIC_FAULT_OUTPUT <= fault_any & FIELD_SUPPLY_OK & ALARM_SUPPLY_OK; // [R21]
            DYNAMIC_FAULT_OUTPUT <= fault_any & FIELD_SUPPLY_OK & ALARM_SUPPLY_OK &
                                    CABINET_BLINK_CLOCK; // [R21]
            REDUNDANT_FAULT_SIGNAL <= sync_fault & SYNC_MODE; // [R18]
        end
    end

endmodule

// [dv/iusm_host.sv]
`timescale 1ns/1ps
module iusm_host (
    // Request
    input wire logic clk,
    input wire logic go,
    input wire logic wr,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    // APB master
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [11:0] paddr = 12'h000,
    output logic [31:0] pwdata = 32'h0,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Result
    output logic done = 1'b0,
    output logic [31:0] rdata = 32'h0,
    output logic err = 1'b0
);
    // ==========
    // Host transfer
    always @(posedge clk) begin
        done <= 1'b0;
        if (psel && penable && pready) begin
            psel <= 1'b0;
            penable <= 1'b0;
            done <= 1'b1;
            rdata <= prdata;
            err <= pslverr;
        end else if (psel) begin
            penable <= 1'b1;
        end else if (go && !done) begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= addr;
            pwdata <= wdata;
        end
    end
endmodule

// [dv/iusm_chk.sv]
`timescale 1ns/1ps
module iusm_chk
    import iusm_pkg::*;
#(
    parameter longint ACC_WD_CYCLES = ACC_WD_CYC,
    parameter longint STRETCH_CYCLES = STRETCH_CYC
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    // Conditions
    input wire logic IO_MODULE_ACCESS,
    input wire logic INTERNAL_CLOCK_OK,
    input wire logic SYNC_MODE,
    input wire logic SINGLE_CHANNEL_FAULT,
    input wire logic FIELD_SUPPLY_OK,
    input wire logic ALARM_SUPPLY_OK,
    // Outputs
    input wire logic PROCESS_ALARM_INTERRUPT_OUT,
    input wire logic EXTENSION_IO_BUS_ENABLE,
    input wire logic CONTROL_ACTIVE_INDICATOR,
    input wire logic REDUNDANT_FAULT_SIGNAL,
    input wire logic STATIC_FAULT_OUTPUT,
    input wire logic CONTROLLER_RESET
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    logic startup_m, done, mapped;
    logic [31:0] idle, hi_len;
    logic [7:0] cmd;
    assign done = PSEL && PENABLE && PREADY;
    assign cmd = PWDATA[7:0] & CMD_MASK;
    assign mapped = PADDR == OFS_SYSCTL || PADDR == OFS_READBACK
        || PADDR == OFS_STATUS || PADDR == OFS_CONTROL;
    // ==========
    // Trackers
    always_ff @(posedge CLOCK) begin
        if (RST || CONTROLLER_RESET)
            startup_m <= 1'b1;
        else if (done && PWRITE && PADDR == OFS_SYSCTL && cmd == CODE_STARTUP_CLR)
            startup_m <= 1'b0;
        else if (done && PWRITE && PADDR == OFS_SYSCTL && cmd == CODE_STARTUP_SET)
            startup_m <= 1'b1;
    end
    always_ff @(posedge CLOCK) begin
        if (RST || CONTROLLER_RESET || (done && mapped)
            || (IO_MODULE_ACCESS && EXTENSION_IO_BUS_ENABLE))
            idle <= 32'h0;
        else
            idle <= idle + 32'h1;
    end
    always_ff @(posedge CLOCK) begin
        if (RST || !CONTROLLER_RESET)
            hi_len <= 32'h0;
        else
            hi_len <= hi_len + 32'h1;
    end
    // ==========
    // Assertions
    a_bus_mirror:
        assert property (EXTENSION_IO_BUS_ENABLE == CONTROL_ACTIVE_INDICATOR) else $error("bus ind");
    a_alarm_gate:
        assert property (!EXTENSION_IO_BUS_ENABLE [*4] |-> !PROCESS_ALARM_INTERRUPT_OUT)
        else $error("alarm");
    a_sync_only:
        assert property (!SYNC_MODE [*4] |-> !REDUNDANT_FAULT_SIGNAL) else $error("sync fault");
    a_pready_once:
        assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY) else $error("pready");
    a_reset_quiet:
        assert property (disable iff (1'b0) RST |=> !PREADY && !CONTROLLER_RESET
            && !STATIC_FAULT_OUTPUT && !EXTENSION_IO_BUS_ENABLE) else $error("reset out");
    a_stretch_len:
        assert property ($fell(CONTROLLER_RESET) |-> hi_len >= STRETCH_CYCLES)
        else $error("short");
    a_startup_hold:
        assert property (startup_m && INTERNAL_CLOCK_OK && $past(INTERNAL_CLOCK_OK, 4)
            |-> !$rose(CONTROLLER_RESET)) else $error("bite");
    a_wd_early:
        assert property ($rose(CONTROLLER_RESET) && INTERNAL_CLOCK_OK
            && $past(INTERNAL_CLOCK_OK, 4) |-> idle >= ACC_WD_CYCLES - 2) else $error("early");
    a_wd_late:
        assert property (!startup_m && idle >= ACC_WD_CYCLES - 2 |-> idle <= ACC_WD_CYCLES + 4)
        else $error("late");
    a_static_fault:
        assert property ((SINGLE_CHANNEL_FAULT && FIELD_SUPPLY_OK && ALARM_SUPPLY_OK
            && !CONTROLLER_RESET) [*4] |-> STATIC_FAULT_OUTPUT) else $error("static");
endmodule
bind iusm_top iusm_chk #(.ACC_WD_CYCLES(ACC_WD_CYCLES), .STRETCH_CYCLES(STRETCH_CYCLES))
    i_iusm_chk (.*);

// [dv/test_io_unit_system_control_monitor.sv]
`timescale 1ns/1ps
module test_io_unit_system_control_monitor
    import iusm_pkg::*;
;
    localparam longint STR = 50;
    logic clk, rst = 1'b1, go = 1'b0, wr = 1'b0, io_acc = 1'b0, alarm_in = 1'b0;
    logic bus_ok = 1'b1, fuse = 1'b1, chan_fault = 1'b0, sync_err = 1'b0, ext_clk = 1'b0;
    logic int_ok = 1'b1, blink = 1'b1, alarm_q = 1'b0, field = 1'b1, sync_md = 1'b0;
    logic [11:0] addr = 12'h000, paddr;
    logic [31:0] wdata = 32'h0, pwdata, prdata, h_rdata;
    logic psel, penable, pwrite, pready, pslverr, h_done, h_err;
    logic alarm_out, bus_en, ctl_ind, fault_ind, stat_f, dyn_f, red_f, ctl_rst;
    int fail_count = 0, samples_checked = 0, cyc = 0, rises = 0, n;
    // Command, mask, status
    logic [25:0] rows [10] = '{{8'h00, 9'h007, 9'h005}, {8'h7E, 9'h001, 9'h000},
        {8'h07, 9'h001, 9'h001}, {8'hF6, 9'h004, 9'h000}, {8'h85, 9'h004, 9'h004},
        {8'h82, 9'h002, 9'h002}, {8'h81, 9'h006, 9'h006}, {8'h05, 9'h007, 9'h007},
        {8'h86, 9'h004, 9'h000}, {8'h84, 9'h018, 9'h000}};
    iusm_top #(.ACC_WD_CYCLES(200), .STRETCH_CYCLES(STR), .CLR_DELAY_CYCLES(20),
        .PERM_ALARM_CYCLES(100)) i_iusm_top (.CLOCK(clk), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .JUMPER_FILTER(1'b1),
        .JUMPER_BUS_CTRL(1'b1), .BUS_SUPPLY_OK(bus_ok), .FIELD_SUPPLY_OK(field),
        .ALARM_SUPPLY_OK(1'b1), .MODULE_FUSE_PRESENT(fuse), .SINGLE_CHANNEL_FAULT(chan_fault),
        .SYNC_MODE(sync_md), .SYNC_COMPARE_ERROR(sync_err), .EXTERNAL_CYCLE_CLOCK(ext_clk),
        .INTERNAL_CLOCK_OK(int_ok), .CABINET_BLINK_CLOCK(blink), .IO_MODULE_ACCESS(io_acc),
        .PROCESS_ALARM_INTERRUPT_IN(alarm_in), .PROCESS_ALARM_INTERRUPT_OUT(alarm_out),
        .EXTENSION_IO_BUS_ENABLE(bus_en), .FAULT_INDICATOR(fault_ind),
        .STATIC_FAULT_OUTPUT(stat_f), .DYNAMIC_FAULT_OUTPUT(dyn_f),
        .REDUNDANT_FAULT_SIGNAL(red_f), .CONTROL_ACTIVE_INDICATOR(ctl_ind),
        .CONTROLLER_RESET(ctl_rst));
    iusm_host i_iusm_host (.clk(clk), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .done(h_done),
        .rdata(h_rdata), .err(h_err));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ==========
    // Tasks
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        go <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        do @(posedge clk); while (!h_done);
        go <= 1'b0;
        @(posedge clk);
    endtask
    task automatic st(input logic [8:0] m, input logic [8:0] e);
        xfer(1'b0, OFS_STATUS, 32'h0);
        chk(h_rdata[8:0] & m, e);
    endtask
    always @(posedge clk) begin
        alarm_q <= alarm_out;
        if (alarm_out && !alarm_q)
            rises <= rises + 1;
        cyc <= cyc + 1;
        if (cyc % 16 == 0)
            ext_clk <= ~ext_clk;
        if (cyc == 6000) begin
            fail_count++;
            tally_and_finish;
        end
    end
    // ==========
    // Sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        st(9'h005, 9'h005);
        chk(bus_en, 1'b1);
        foreach (rows[i]) begin
            xfer(1'b1, OFS_SYSCTL, {24'h0, rows[i][25:18]});
            st(rows[i][17:9], rows[i][8:0]);
            xfer(1'b0, OFS_READBACK, 32'h0);
            chk(h_rdata[7:0], rows[i][25:18]);
        end
        chk({stat_f, dyn_f, fault_ind}, 3'h7);
        xfer(1'b1, OFS_SYSCTL, 32'h83);
        st(9'h102, 9'h102);
        xfer(1'b1, OFS_SYSCTL, 32'h82);
        for (int i = 0; i < 30; i++) begin
            @(posedge clk);
            chk(stat_f, 1'b1);
        end
        xfer(1'b1, OFS_SYSCTL, 32'h83);
        repeat (30) @(posedge clk);
        st(9'h102, 9'h000);
        chk(fault_ind, 1'b0);
        for (int i = 0; i < 5; i++) begin
            field <= i != 4;
            bus_ok <= i != 0;
            fuse <= i != 1;
            chan_fault <= i >= 2;
            blink <= i != 3;
            repeat (6) @(posedge clk);
            chk({stat_f, dyn_f, fault_ind}, i == 3 ? 3'h4 : i == 4 ? 3'h1 : 3'h7);
            field <= 1'b1;
            bus_ok <= 1'b1;
            fuse <= 1'b1;
            chan_fault <= 1'b0;
            blink <= 1'b1;
            xfer(1'b1, OFS_SYSCTL, 32'h83);
            repeat (30) @(posedge clk);
        end
        sync_err <= 1'b1;
        repeat (8) @(posedge clk);
        chk(red_f, 1'b0);
        st(9'h040, 9'h000);
        sync_md <= 1'b1;
        repeat (4) @(posedge clk);
        chk(red_f, 1'b1);
        sync_err <= 1'b0;
        sync_md <= 1'b0;
        xfer(1'b1, OFS_CONTROL, 32'h0);
        repeat (3) @(posedge clk);
        chk({bus_en, ctl_ind}, 2'h0);
        xfer(1'b1, OFS_CONTROL, 32'h1);
        repeat (3) @(posedge clk);
        chk({bus_en, ctl_ind}, 2'h3);
        xfer(1'b0, OFS_JUMPER, 32'h0);
        chk({h_err, h_rdata[1:0]}, 3'h3);
        xfer(1'b0, 12'h020, 32'h0);
        chk(h_err, 1'b1);
        alarm_in <= 1'b1;
        repeat (150) @(posedge clk);
        xfer(1'b1, OFS_SYSCTL, 32'h83);
        st(9'h008, 9'h008);
        rises <= 0;
        xfer(1'b1, OFS_SYSCTL, 32'h84);
        repeat (20) @(posedge clk);
        chk(rises, 32'h1);
        st(9'h008, 9'h008);
        alarm_in <= 1'b0;
        int_ok <= 1'b0;
        repeat (5) @(posedge clk);
        chk(ctl_rst, 1'b1);
        int_ok <= 1'b1;
        for (n = 0; n < 400 && ctl_rst; n++) @(posedge clk);
        repeat (300) @(posedge clk);
        chk(ctl_rst, 1'b0);
        xfer(1'b1, OFS_SYSCTL, 32'h06);
        repeat (3) begin
            repeat (150) @(posedge clk);
            io_acc <= 1'b1;
            @(posedge clk);
            io_acc <= 1'b0;
        end
        chk(ctl_rst, 1'b0);
        for (n = 0; n < 400 && !ctl_rst; n++) @(posedge clk);
        chk(ctl_rst, 1'b1);
        for (n = 0; n < 400 && ctl_rst; n++) @(posedge clk);
        chk(n >= STR, 1'b1);
        repeat (3) @(posedge clk);
        st(9'h001, 9'h001);
        tally_and_finish;
    end
endmodule
